// ### rtl/pfm_pkg.sv
package pfm_pkg;

	// ----------------------------------------------------------------
	// register map and field layout
	// ----------------------------------------------------------------
	localparam int          PFM_AW          = 5;
	localparam logic [4:0]  PFM_OFF_PA_CTL  = 5'h00;
	localparam logic [4:0]  PFM_OFF_PB_CTL  = 5'h04;
	localparam logic [4:0]  PFM_OFF_PC_CTL  = 5'h08;
	localparam logic [4:0]  PFM_OFF_FSH     = 5'h0C;
	localparam logic [4:0]  PFM_OFF_PD_CTL  = 5'h10;
	localparam logic [4:0]  PFM_OFF_LED     = 5'h14;
	localparam logic [4:0]  PFM_OFF_MISC    = 5'h18;
	localparam logic [4:0]  PFM_OFF_STATUS  = 5'h1C;

	// byte lanes inside a port control word
	localparam int          PFM_F_OUT       = 0;
	localparam int          PFM_F_DIR       = 8;
	localparam int          PFM_F_AFEN      = 16;
	localparam int          PFM_F_FSL       = 24;
	// port d control bits
	localparam int          PFM_D_OUT       = 0;
	localparam int          PFM_D_DIR       = 1;
	localparam int          PFM_D_AFEN      = 2;
	localparam int          PFM_D_HD        = 3;
	// misc bits
	localparam int          PFM_M_LARGE     = 0;
	// status layout
	localparam int          PFM_S_B         = 8;
	localparam int          PFM_S_C         = 16;
	localparam int          PFM_S_D         = 24;
	localparam int          PFM_S_XTAL      = 25;
	localparam int          PFM_S_WOSC      = 26;

	// writable bits per register
	localparam logic [31:0] PFM_MASK_WIDE   = 32'hFFFFFFFF;
	localparam logic [31:0] PFM_MASK_NARROW = 32'h0F0F0F0F;
	localparam logic [31:0] PFM_MASK_FSH    = 32'h000F0FFF;
	localparam logic [31:0] PFM_MASK_PD     = 32'h0000000F;
	localparam logic [31:0] PFM_MASK_LED    = 32'h000000FF;
	localparam logic [31:0] PFM_MASK_MISC   = 32'h00000001;

	// reset values: port d bit 0 starts in its reset role
	localparam logic [31:0] PFM_RST_PORT    = 32'h00000000;
	localparam logic [31:0] PFM_RST_PD      = 32'h00000004;
	localparam logic [1:0]  PFM_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  PFM_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PFM_LED_3MA  = 2'h0,
		PFM_LED_7MA  = 2'h1,
		PFM_LED_13MA = 2'h2,
		PFM_LED_20MA = 2'h3
	} pfm_led_level_t;

	typedef enum logic [3:0] {
		PFM_SEL_PA, PFM_SEL_PB, PFM_SEL_PC, PFM_SEL_FSH, PFM_SEL_PD,
		PFM_SEL_LED, PFM_SEL_MISC, PFM_SEL_STATUS, PFM_SEL_NONE
	} pfm_reg_sel_t;

	// signals driven by the peripherals toward the pins
	typedef struct packed {
		logic t0_comp_o;
		logic t0_comp_oe;
		logic t0_out_o;
		logic uart_de_o;
		logic uart_txd_o;
		logic t1_comp_o;
		logic t1_comp_oe;
		logic t1_out_o;
		logic t2_comp_o;
		logic t2_comp_oe;
		logic t2_out_o;
		logic i2c_scl_low;
		logic i2c_sda_low;
		logic cmp0_o;
	} pfm_periph_out_t;

	// pin levels handed to the peripherals
	typedef struct packed {
		logic t0_in;
		logic uart_cts;
		logic uart_rxd;
		logic t1_in;
		logic t2_in;
		logic i2c_scl;
		logic i2c_sda;
		logic ext_clk;
		logic ext_reset_n;
	} pfm_periph_in_t;

	// idle levels: rxd, i2c and reset lines high, the rest low
	localparam pfm_periph_in_t PFM_PIN_IN_RST = 9'h04D;

endpackage

// ### rtl/pfm_port_mux.sv
`timescale 1ns/100ps
module pfm_port_mux (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [pfm_pkg::PFM_AW-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [pfm_pkg::PFM_AW-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       xtal_osc_en,
	input  wire logic                       watch_osc_en,
	input  wire logic                       reset_out_req,
	input  wire pfm_pkg::pfm_periph_out_t   periph_o,
	output pfm_pkg::pfm_periph_in_t         periph_i,
	input  wire logic [7:0]                 port_a_i,
	output logic [7:0]                      port_a_o,
	output logic [7:0]                      port_a_oe,
	input  wire logic [3:0]                 port_b_i,
	output logic [3:0]                      port_b_o,
	output logic [3:0]                      port_b_oe,
	input  wire logic [3:0]                 port_c_i,
	output logic [3:0]                      port_c_o,
	output logic [3:0]                      port_c_oe,
	input  wire logic                       port_d_bit0_pin_i,
	output logic                            port_d_bit0_pin_o,
	output logic                            port_d_bit0_pin_oe,
	output logic                            pd0_pullup_en,
	output logic                            pd0_high_drive,
	output logic [3:0]                      led_sink_en,
	output pfm_pkg::pfm_led_level_t [3:0]   led_level,
	output logic [5:0]                      analog_route_en
);
	import pfm_pkg::*;

	// ----------------------------------------------------------------
	// register bus decode
	// ----------------------------------------------------------------
	function automatic pfm_reg_sel_t reg_sel(input logic [PFM_AW-1:0] a);
		case (a)
			PFM_OFF_PA_CTL: reg_sel = PFM_SEL_PA;
			PFM_OFF_PB_CTL: reg_sel = PFM_SEL_PB;
			PFM_OFF_PC_CTL: reg_sel = PFM_SEL_PC;
			PFM_OFF_FSH:    reg_sel = PFM_SEL_FSH;
			PFM_OFF_PD_CTL: reg_sel = PFM_SEL_PD;
			PFM_OFF_LED:    reg_sel = PFM_SEL_LED;
			PFM_OFF_MISC:   reg_sel = PFM_SEL_MISC;
			PFM_OFF_STATUS: reg_sel = PFM_SEL_STATUS;
			default:        reg_sel = PFM_SEL_NONE;
		endcase
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = ((old & ~m) | (d & m)) & mask;
	endfunction

	logic                  aw_hold_reg;
	logic                  w_hold_reg;
	logic [PFM_AW-1:0]     awaddr_reg;
	logic [31:0]           wdata_reg;
	logic [3:0]            wstrb_reg;
	logic [31:0]           pa_reg, pb_reg, pc_reg, fsh_reg;
	logic [31:0]           pd_reg, led_reg, misc_reg;
	logic [16:0]           sync1_reg, sync2_reg;
	pfm_reg_sel_t          wsel, rsel;
	logic                  do_write;
	logic [31:0]           rd_word;
	logic [31:0]           status_word;
	// one write and one read may be outstanding; both addr and data
	// are parked until the pair is complete, in either order
	assign s_axi_awready = !aw_hold_reg;
	assign s_axi_wready  = !w_hold_reg;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wsel          = reg_sel(awaddr_reg);
	assign rsel          = reg_sel(s_axi_araddr);
	// pd0 wake enable is not implemented, so no such bit is stored
	assign status_word = {5'h00, watch_osc_en, xtal_osc_en,
		sync2_reg[16], 4'h0, sync2_reg[15:12], 4'h0,
		sync2_reg[11:8], sync2_reg[7:0]};
	// read mux
	always_comb begin
		case (rsel)
			PFM_SEL_PA:     rd_word = pa_reg;
			PFM_SEL_PB:     rd_word = pb_reg;
			PFM_SEL_PC:     rd_word = pc_reg;
			PFM_SEL_FSH:    rd_word = fsh_reg;
			PFM_SEL_PD:     rd_word = pd_reg;
			PFM_SEL_LED:    rd_word = led_reg;
			PFM_SEL_MISC:   rd_word = misc_reg;
			PFM_SEL_STATUS: rd_word = status_word;
			default:        rd_word = 32'h00000000;
		endcase
	end
	// write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg  <= 1'b0;
			w_hold_reg   <= 1'b0;
			awaddr_reg   <= '0;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= PFM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wsel == PFM_SEL_NONE ||
					wsel == PFM_SEL_STATUS) ? PFM_RESP_SLVERR : PFM_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// configuration registers; status is read-only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pa_reg   <= PFM_RST_PORT;
			pb_reg   <= PFM_RST_PORT;
			pc_reg   <= PFM_RST_PORT;
			fsh_reg  <= PFM_RST_PORT;
			pd_reg   <= PFM_RST_PD;
			led_reg  <= PFM_RST_PORT;
			misc_reg <= PFM_RST_PORT;
		end else if (do_write) begin
			case (wsel)
				PFM_SEL_PA:   pa_reg   <= merge(pa_reg, wdata_reg,
					wstrb_reg, PFM_MASK_WIDE);
				PFM_SEL_PB:   pb_reg   <= merge(pb_reg, wdata_reg,
					wstrb_reg, PFM_MASK_NARROW);
				PFM_SEL_PC:   pc_reg   <= merge(pc_reg, wdata_reg,
					wstrb_reg, PFM_MASK_NARROW);
				// kept for software, steers nothing
				PFM_SEL_FSH:  fsh_reg  <= merge(fsh_reg, wdata_reg,
					wstrb_reg, PFM_MASK_FSH);
				PFM_SEL_PD:   pd_reg   <= merge(pd_reg, wdata_reg,
					wstrb_reg, PFM_MASK_PD);
				PFM_SEL_LED:  led_reg  <= merge(led_reg, wdata_reg,
					wstrb_reg, PFM_MASK_LED);
				PFM_SEL_MISC: misc_reg <= merge(misc_reg, wdata_reg,
					wstrb_reg, PFM_MASK_MISC);
				default:      misc_reg <= misc_reg;
			endcase
		end
	end
	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= PFM_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= (rsel == PFM_SEL_NONE) ? PFM_RESP_SLVERR
				: PFM_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	// pads are asynchronous to aclk; stage one feeds stage two only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {port_d_bit0_pin_i, port_c_i, port_b_i, port_a_i};
			sync2_reg <= sync1_reg;
		end
	end
	// ----------------------------------------------------------------
	// field views
	// ----------------------------------------------------------------
	logic [7:0] a_out, a_dir, a_afen, a_fsl;
	logic [3:0] b_out, b_dir, b_afen, b_fsl;
	logic [3:0] c_out, c_dir, c_afen, c_fsl;
	logic [7:0] a_sync, a_kill;
	logic [3:0] b_sync, c_sync;
	logic       large_pkg, pd_afen;

	assign a_out     = pa_reg[PFM_F_OUT  +: 8];
	assign a_dir     = pa_reg[PFM_F_DIR  +: 8];
	assign a_afen    = pa_reg[PFM_F_AFEN +: 8];
	assign a_fsl     = pa_reg[PFM_F_FSL  +: 8];
	assign b_out     = pb_reg[PFM_F_OUT  +: 4];
	assign b_dir     = pb_reg[PFM_F_DIR  +: 4];
	assign b_afen    = pb_reg[PFM_F_AFEN +: 4];
	assign b_fsl     = pb_reg[PFM_F_FSL  +: 4];
	assign c_out     = pc_reg[PFM_F_OUT  +: 4];
	assign c_dir     = pc_reg[PFM_F_DIR  +: 4];
	assign c_afen    = pc_reg[PFM_F_AFEN +: 4];
	assign c_fsl     = pc_reg[PFM_F_FSL  +: 4];
	assign a_sync    = sync2_reg[7:0];
	assign b_sync    = sync2_reg[11:8];
	assign c_sync    = sync2_reg[15:12];
	assign large_pkg = misc_reg[PFM_M_LARGE];
	assign pd_afen   = pd_reg[PFM_D_AFEN];
	// oscillators take their pins whatever else is set
	assign a_kill = {4'h0, {2{watch_osc_en}}, {2{xtal_osc_en}}};

	// ----------------------------------------------------------------
	// port a alternate functions
	// ----------------------------------------------------------------
	logic [7:0] alt_a_o, alt_a_oe, a_o_next, a_oe_next, a_live;
	logic       t2_sel;

	assign t2_sel = a_fsl[4] && !large_pkg;
	assign alt_a_o[0]  = !a_fsl[0] && periph_o.t0_comp_o;
	assign alt_a_oe[0] = !a_fsl[0] && periph_o.t0_comp_oe;
	assign alt_a_o[1]  = !a_fsl[1] && periph_o.t0_out_o;
	assign alt_a_oe[1] = !a_fsl[1];
	assign alt_a_o[2]  = !a_fsl[2] && periph_o.uart_de_o;
	assign alt_a_oe[2] = !a_fsl[2];
	assign alt_a_o[3]  = 1'b0;
	assign alt_a_oe[3] = 1'b0;
	assign alt_a_o[4]  = t2_sel && periph_o.t2_comp_o;
	assign alt_a_oe[4] = t2_sel && periph_o.t2_comp_oe;
	assign alt_a_o[5]  = a_fsl[5] ? (!large_pkg && periph_o.t2_out_o)
		: periph_o.uart_txd_o;
	assign alt_a_oe[5] = !a_fsl[5] || !large_pkg;
	// i2c lines are open-drain: drive low only
	assign alt_a_o[6]  = !a_fsl[6] && periph_o.t1_comp_o;
	assign alt_a_oe[6] = a_fsl[6] ? periph_o.i2c_scl_low
		: periph_o.t1_comp_oe;
	assign alt_a_o[7]  = !a_fsl[7] && periph_o.t1_out_o;
	assign alt_a_oe[7] = a_fsl[7] ? periph_o.i2c_sda_low : 1'b1;
	// override first, then peripheral, then plain port
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pa
			assign a_o_next[gi]  = !a_kill[gi] && (a_afen[gi]
				? alt_a_o[gi] : a_out[gi]);
			assign a_oe_next[gi] = !a_kill[gi] && (a_afen[gi]
				? alt_a_oe[gi] : a_dir[gi]);
			assign a_live[gi]    = a_afen[gi] && !a_kill[gi];
		end
	endgenerate
	// ----------------------------------------------------------------
	// ports b and c
	// ----------------------------------------------------------------
	logic [3:0] b_o_next, b_oe_next, c_o_next, c_oe_next;
	logic [3:0] alt_c_oe, led_next;
	logic [5:0] ana_next;
	// port b alternate uses are all inputs, so the driver is off
	assign b_o_next  = b_out & ~b_afen;
	assign b_oe_next = b_dir & ~b_afen;
	// led sink only exists on port c, selected by a set fsl bit
	assign led_next  = c_afen & c_fsl;
	assign alt_c_oe  = {!c_fsl[3], 3'h0};
	assign c_o_next  = {c_afen[3] ? (!c_fsl[3] && periph_o.cmp0_o)
		: c_out[3], c_out[2:0] & ~c_afen[2:0]};
	assign c_oe_next = (c_afen & alt_c_oe) | (~c_afen & c_dir);
	assign ana_next  = {led_next[2:0], b_afen[3] && b_fsl[3],
		b_afen[1:0] & b_fsl[1:0]};
	// ----------------------------------------------------------------
	// port d bit 0 and peripheral inputs
	// ----------------------------------------------------------------
	logic           d_o_next, d_oe_next, d_pullup_next;
	pfm_periph_in_t pin_next;
	// reset role: open-drain pulldown only on request, pulled up
	assign d_oe_next     = pd_afen ? reset_out_req : pd_reg[PFM_D_DIR];
	assign d_o_next      = !pd_afen && pd_reg[PFM_D_OUT];
	assign d_pullup_next = pd_afen;
	// idle-high lines read high when not routed
	assign pin_next.t0_in    = a_live[0] && !a_fsl[0] && a_sync[0];
	assign pin_next.uart_cts = a_live[3] && !a_fsl[3] && a_sync[3];
	assign pin_next.uart_rxd = !(a_afen[4] && !a_fsl[4]) || a_sync[4];
	assign pin_next.t2_in    = a_afen[4] && t2_sel && a_sync[4];
	assign pin_next.t1_in    = a_afen[6] && !a_fsl[6] && a_sync[6];
	assign pin_next.i2c_scl  = !(a_afen[6] && a_fsl[6]) || a_sync[6];
	assign pin_next.i2c_sda  = !(a_afen[7] && a_fsl[7]) || a_sync[7];
	assign pin_next.ext_clk  = b_afen[3] && !b_fsl[3] && b_sync[3];
	assign pin_next.ext_reset_n = !pd_afen || sync2_reg[16];
	// every pin-facing output is registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_o           <= 8'h00;
			port_a_oe          <= 8'h00;
			port_b_o           <= 4'h0;
			port_b_oe          <= 4'h0;
			port_c_o           <= 4'h0;
			port_c_oe          <= 4'h0;
			port_d_bit0_pin_o  <= 1'b0;
			port_d_bit0_pin_oe <= 1'b0;
			pd0_pullup_en      <= 1'b1;
			pd0_high_drive     <= 1'b0;
			led_sink_en        <= 4'h0;
			analog_route_en    <= 6'h00;
			periph_i           <= PFM_PIN_IN_RST;
		end else begin
			port_a_o           <= a_o_next;
			port_a_oe          <= a_oe_next;
			port_b_o           <= b_o_next;
			port_b_oe          <= b_oe_next;
			port_c_o           <= c_o_next;
			port_c_oe          <= c_oe_next;
			port_d_bit0_pin_o  <= d_o_next;
			port_d_bit0_pin_oe <= d_oe_next;
			pd0_pullup_en      <= d_pullup_next;
			pd0_high_drive     <= pd_reg[PFM_D_HD];
			led_sink_en        <= led_next;
			analog_route_en    <= ana_next;
			periph_i           <= pin_next;
		end
	end
	// levels straight from the led register, two bits per pin
	for (genvar gl = 0; gl < 4; gl++) begin : g_led
		assign led_level[gl] = pfm_led_level_t'(led_reg[2*gl+:2]);
	end
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_XTAL_OVR: assert property (xtal_osc_en |=> port_a_oe[1:0] == 2'h0
		&& port_a_o[1:0] == 2'h0) else $error("crystal pins driven");
	AST_WOSC_OVR: assert property (watch_osc_en |=>
		port_a_oe[3:2] == 2'h0 && !periph_i.uart_cts)
		else $error("watch pins not released");
	AST_LED_SEL: assert property ((c_afen & c_fsl) == 4'h0 |=>
		led_sink_en == 4'h0) else $error("led on unselected");
	AST_PD0_RST: assert property ($rose(aresetn) |-> pd0_pullup_en
		&& !port_d_bit0_pin_o) else $error("pd0 not reset role");
	AST_PD0_OD: assert property (pd0_pullup_en |-> !port_d_bit0_pin_o)
		else $error("pd0 drives high in reset role");
	AST_PD0_GPIO: assert property (!pd_afen && pd_reg[PFM_D_DIR] |=>
		port_d_bit0_pin_oe && port_d_bit0_pin_o == $past(pd_reg[PFM_D_OUT]))
		else $error("pd0 gpio output wrong");
	AST_PD0_HD: assert property ($rose(pd_reg[PFM_D_HD]) |=> pd0_high_drive)
		else $error("high drive not applied");
	AST_PA5_LARGE: assert property (large_pkg && a_afen[5] && a_fsl[5]
		|=> !port_a_oe[5]) else $error("reserved pa5 driven");
	AST_PB_IN: assert property (b_afen[0] |=> !port_b_oe[0])
		else $error("pb0 driven in analog use");
	AST_GPIO: assert property (!a_afen[7] |=> port_a_oe[7] == $past(a_dir[7])
		&& port_a_o[7] == $past(a_out[7])) else $error("pa7 gpio wrong");
	AST_CMP0: assert property (c_afen[3] && !c_fsl[3] |=> port_c_oe[3]
		&& port_c_o[3] == $past(periph_o.cmp0_o))
		else $error("pc3 comparator not routed");
	COV_WRITE: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
	COV_XTAL:  cover property ($rose(xtal_osc_en) && a_afen[0]);
	COV_LED:   cover property ($rose(led_sink_en[3]));
	COV_PD0:   cover property ($fell(pd_afen));

endmodule

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
	import pfm_pkg::*;
	// ----------------------------------------------------------
	// signals, clock and device under test
	// ----------------------------------------------------------
	logic            aclk, aresetn, awvalid, wvalid, bready, arvalid;
	logic            rready, awready, wready, bvalid, arready, rvalid;
	logic            xo, wo, rq, pdi, pdo, pdoe, pu, hd, fs;
	logic [4:0]      awaddr, araddr;
	logic [31:0]     wdata, rdata, d, v;
	logic [1:0]      bresp, rresp, r;
	logic [7:0]      pai, pao, paoe, lvl;
	logic [3:0]      pbi, pbo, pboe, pci, pco, pcoe, led;
	logic [5:0]      ana;
	pfm_periph_out_t po;
	pfm_periph_in_t  pin;
	integer          seed, miscompares, num_checks, i, j;

	// 20 MHz system clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	pfm_port_mux dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .xtal_osc_en(xo),
		.watch_osc_en(wo), .reset_out_req(rq), .periph_o(po),
		.periph_i(pin), .port_a_i(pai), .port_a_o(pao), .port_a_oe(paoe),
		.port_b_i(pbi), .port_b_o(pbo), .port_b_oe(pboe), .port_c_i(pci),
		.port_c_o(pco), .port_c_oe(pcoe), .port_d_bit0_pin_i(pdi),
		.port_d_bit0_pin_o(pdo), .port_d_bit0_pin_oe(pdoe),
		.pd0_pullup_en(pu), .pd0_high_drive(hd), .led_sink_en(led),
		.led_level(lvl), .analog_route_en(ana));

	// one comparison, counted; four-state equality catches unknowns
	task automatic ck(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 99) begin
			miscompares++;
			test_done;
		end
	endtask
	// handshakes are judged mid-cycle, where nothing is moving
	task automatic wr(input logic [4:0] a, input logic [31:0] x);
		logic ta, tw, tk;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tk = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tk) break;
		end
		bready <= 1'b0;
		tmo(n);
	endtask
	task automatic rd(input logic [4:0] a);
		logic ta, tk;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tk = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tk) break;
		end
		rready <= 1'b0;
		tmo(n);
	endtask
	// four edges cover register update, pad register and input sync
	task automatic st;
		repeat (4) @(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic rnd(input logic o);
		@(posedge aclk);
		po <= pfm_periph_out_t'($random(seed));
		{pai, pbi, pci, pdi} <= 17'($random(seed));
		{xo, wo, rq} <= {o, o, 1'b0};
	endtask

	// main sequence
	initial begin
		seed = 86938;
		miscompares = 0;
		num_checks = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{xo, wo, rq, pdi, po, pai, pbi, pci, awaddr, araddr, wdata} = '0;
		repeat (9) @(posedge aclk);
		@(negedge aclk);
		ck("pin_rst", 9'h04D, pin);
		@(posedge aclk);
		aresetn <= 1'b1;
		rq <= 1'b1;
		st;
		ck("pd0_rst", 3'b110, {pu, pdoe, pdo});
		rd(PFM_OFF_PD_CTL);
		ck("pd_ctl", PFM_RST_PD, d);
		ck("rresp", PFM_RESP_OKAY, r);
		wr(PFM_OFF_STATUS, '1);
		ck("bresp", PFM_RESP_SLVERR, r);
		for (i = 0; i < 4; i++) begin
			fs = i[0];
			wr(PFM_OFF_FSH, $random(seed));
			wr(PFM_OFF_PA_CTL, {{8{fs}}, 24'hFF0000});
			rnd(i[1]);
			st;
			if (i[1])
				ck("pa_osc", 0, {pao[3:0], paoe[3:0]});
			else if (fs)
				ck("pa_rsv", 0, paoe[3:0]);
			else
				ck("pa_t0", {po.t0_comp_o, po.t0_comp_oe, po.t0_out_o},
					{pao[0], paoe[0], pao[1]});
			if (fs) begin
				ck("pa_t2", {po.t2_out_o, pai[4]}, {pao[5], pin.t2_in});
				ck("pa_scl", {po.i2c_scl_low, po.i2c_sda_low, pai[7:6]},
					{paoe[6], paoe[7], pin.i2c_sda, pin.i2c_scl});
			end else begin
				ck("pa_ua", {po.uart_txd_o, pai[4]}, {pao[5], pin.uart_rxd});
				ck("pa_t1", {po.t1_comp_o, po.t1_comp_oe}, {pao[6], paoe[6]});
				ck("pa_in", {pai[0] & ~i[1], pai[3] & ~i[1], pai[6]},
					{pin.t0_in, pin.uart_cts, pin.t1_in});
			end
		end
		wr(PFM_OFF_MISC, 32'h1);
		st;
		ck("pa_large", 0, {pao[5], paoe[5]});
		v = $random(seed);
		wr(PFM_OFF_PA_CTL, {16'hFF00, 8'hFF, v[7:0]});
		rnd(1'b0);
		st;
		ck("pa_gpio", {8'hFF, v[7:0]}, {paoe, pao});
		// first pass sets every current level once
		for (i = 0; i < 2; i++) begin
			v = i ? $random(seed) : 32'hE4;
			wr(PFM_OFF_LED, v);
			wr(PFM_OFF_PC_CTL, {i[0] ? 8'h0F : 8'h00, 24'h0F0000});
			st;
			for (j = 0; j < 4; j++)
				ck("led_lvl", v[2*j+:2], lvl[2*j+:2]);
			ck("led_pc3", i[0], led[3]);
			ck("pc_ana", {3{i[0]}}, ana[5:3]);
			if (i == 0)
				ck("pc3_cmp", {5'h0, po.cmp0_o}, {led, pcoe[3], pco[3]} ^ 6'h2);
		end
		wr(PFM_OFF_PB_CTL, 32'h00080000);
		rnd(1'b0);
		st;
		ck("pb3_clk", {pbi[3], pdi, 1'b0},
			{pin.ext_clk, pin.ext_reset_n, pdoe});
		wr(PFM_OFF_PB_CTL, 32'h0B0B0F0F);
		st;
		ck("pb_ana", 3'b111, ana[2:0]);
		ck("pb_gpio", 8'h44, {pbo, pboe});
		wr(PFM_OFF_PD_CTL, 32'hB);
		st;
		ck("pd0_gpio", 4'hD, {pdo, pdoe, pu, hd});
		test_done;
	end
endmodule
